// file: verilog/dual_core_boot_sequencer.sv
// dual core boot sequencer: orders release of subsystems, decodes straps
// assumes rst_i is the merged master reset (power-up, pin, debug, soft,
// watchdog) already synchronised to clk_i
`timescale 1ns/10ps
module dual_core_boot_sequencer #(
  parameter bit ENGINEERING_VERSION = 1'b0,
  parameter int DEV_INIT = boot_seq_pkg::DEV_INIT_CYCLES,
  parameter int MST_INIT = boot_seq_pkg::MST_INIT_CYCLES,
  parameter int CTL_INIT = boot_seq_pkg::CTL_INIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic boot_strap_one_i,
  input wire logic boot_strap_two_i,
  input wire logic boot_strap_three_i,
  input wire logic boot_strap_four_i,
  input wire logic master_to_control_wake_irq_i,
  input wire logic flash_valid_i,
  input wire logic load_done_i,
  output logic control_reset_o,
  output logic analog_bus_reset_o,
  output logic control_idle_o,
  output logic control_running_o,
  output logic mode_valid_o,
  output logic [3:0] boot_mode_o,
  output boot_seq_pkg::boot_sel_t boot_sel_o,
  output logic loader_start_o,
  output logic app_running_o,
  output logic hard_fault_o
);
  typedef enum logic [2:0] {
    M_DEV_INIT, M_MST_INIT, M_RELEASE, M_SAMPLE, M_LOAD, M_BRANCH, M_APP,
    M_FAULT
  } master_state_t;
  typedef enum logic [1:0] {C_HELD, C_INIT, C_IDLE, C_RUN} ctl_state_t;

  master_state_t mstate;
  ctl_state_t cstate;
  logic [15:0] mcount;
  logic [15:0] ccount;
  logic [3:0] straps_sync;
  logic fault_req;

  // map a strap word to its boot choice
  function automatic boot_seq_pkg::boot_sel_t decode_mode(
    input logic [3:0] m, input logic eng);
    boot_seq_pkg::boot_sel_t s;
    s.src = boot_seq_pkg::SRC_FLASH;
    s.alt_pins = 1'b0;
    s.fast_flash = 1'b0;
    case (m)
      boot_seq_pkg::MODE_PARALLEL: s.src = boot_seq_pkg::SRC_PARALLEL;
      boot_seq_pkg::MODE_RAM: s.src = boot_seq_pkg::SRC_RAM;
      boot_seq_pkg::MODE_SERIAL_SLAVE: begin
        s.src = boot_seq_pkg::SRC_SERIAL_SLAVE;
      end
      boot_seq_pkg::MODE_CAN: s.src = boot_seq_pkg::SRC_CAN;
      boot_seq_pkg::MODE_ETH_A: s.src = boot_seq_pkg::SRC_ETHERNET;
      boot_seq_pkg::MODE_ETH_B: begin
        s.src = boot_seq_pkg::SRC_ETHERNET;
        s.alt_pins = 1'b1;
      end
      boot_seq_pkg::MODE_SYNC_MASTER: begin
        s.src = boot_seq_pkg::SRC_SYNC_MASTER;
      end
      boot_seq_pkg::MODE_TWO_WIRE_MASTER: begin
        s.src = boot_seq_pkg::SRC_TWO_WIRE_MASTER;
      end
      boot_seq_pkg::MODE_OTP: begin
        if (eng) begin
          s.src = boot_seq_pkg::SRC_OTP;
        end
      end
      boot_seq_pkg::MODE_FLASH: s.src = boot_seq_pkg::SRC_FLASH;
      boot_seq_pkg::MODE_FAST_FLASH: begin
        s.src = boot_seq_pkg::SRC_FLASH;
        s.fast_flash = 1'b1;
      end
      default: s.src = boot_seq_pkg::SRC_FLASH;
    endcase
    return s;
  endfunction

  // straps come from pads, so they are synchronised before use
  strap_sync #(
    .W(4)
  ) u_strap_sync (
    .clk_i(clk_i),
    .async_i({boot_strap_four_i, boot_strap_three_i,
              boot_strap_two_i, boot_strap_one_i}),
    .sync_o(straps_sync)
  );

  // a branch to blank flash faults; the fault then restarts the boot
  assign fault_req = (mstate == M_BRANCH) &&
                     (boot_sel_o.src == boot_seq_pkg::SRC_FLASH) &&
                     !flash_valid_i;

  // master boot sequence, restarted by every reset exit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mstate <= M_DEV_INIT;
      mcount <= 16'h0000;
    end else begin
      case (mstate)
        M_DEV_INIT: begin
          mcount <= mcount + 16'h0001;
          if (mcount == 16'(DEV_INIT - 1)) begin
            mcount <= 16'h0000;
            mstate <= M_MST_INIT;
          end
        end
        M_MST_INIT: begin
          mcount <= mcount + 16'h0001;
          if (mcount == 16'(MST_INIT - 1)) begin
            mcount <= 16'h0000;
            mstate <= M_RELEASE;
          end
        end
        M_RELEASE: mstate <= M_SAMPLE;
        M_SAMPLE: mstate <= M_LOAD;
        M_LOAD: begin
          // branch modes need no loader; others wait for load completion
          if (boot_sel_o.src == boot_seq_pkg::SRC_RAM ||
              boot_sel_o.src == boot_seq_pkg::SRC_FLASH ||
              boot_sel_o.src == boot_seq_pkg::SRC_OTP || load_done_i) begin
            mstate <= M_BRANCH;
          end
        end
        M_BRANCH: mstate <= fault_req ? M_FAULT : M_APP;
        M_APP: mstate <= M_APP;
        M_FAULT: begin
          mstate <= M_DEV_INIT;
          mcount <= 16'h0000;
        end
        default: mstate <= M_DEV_INIT;
      endcase
    end
  end

  // strap capture happens once per boot pass, then holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_mode_o <= 4'h0;
      boot_sel_o <= '0;
      mode_valid_o <= 1'b0;
    end else if (mstate == M_SAMPLE && !mode_valid_o) begin
      boot_mode_o <= straps_sync;
      boot_sel_o <= decode_mode(straps_sync, ENGINEERING_VERSION);
      mode_valid_o <= 1'b1;
    end else if (mstate == M_FAULT) begin
      mode_valid_o <= 1'b0; // fault restarts the pass, so resample
    end
  end

  // subsystem reset outputs, held until the master releases them
  always_ff @(posedge clk_i) begin
    if (rst_i || mstate == M_FAULT) begin
      control_reset_o <= 1'b1;
      analog_bus_reset_o <= 1'b1;
    end else if (mstate == M_RELEASE) begin
      control_reset_o <= 1'b0;
      analog_bus_reset_o <= 1'b0;
    end
  end

  // control boot, runs alongside the master after release
  always_ff @(posedge clk_i) begin
    if (rst_i || control_reset_o) begin
      cstate <= C_HELD;
      ccount <= 16'h0000;
    end else begin
      case (cstate)
        C_HELD: cstate <= C_INIT;
        C_INIT: begin
          ccount <= ccount + 16'h0001;
          if (ccount == 16'(CTL_INIT - 1)) begin
            cstate <= C_IDLE;
          end
        end
        C_IDLE: begin
          if (master_to_control_wake_irq_i) begin
            cstate <= C_RUN;
          end
        end
        C_RUN: cstate <= C_RUN;
        default: cstate <= C_HELD;
      endcase
    end
  end

  // status outputs registered so they are clean from reset onward
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_idle_o <= 1'b0;
      control_running_o <= 1'b0;
      loader_start_o <= 1'b0;
      app_running_o <= 1'b0;
      hard_fault_o <= 1'b0;
    end else begin
      control_idle_o <= (cstate == C_IDLE);
      control_running_o <= (cstate == C_RUN);
      loader_start_o <= (mstate == M_SAMPLE);
      app_running_o <= (mstate == M_APP);
      hard_fault_o <= fault_req;
    end
  end
endmodule

// file: verilog/boot_seq_pkg.sv
// boot sequencer package: phases, boot sources, decode constants
// assumes a single 10 MHz clock domain and a synchronous high reset
package boot_seq_pkg;
  localparam int CLK_HZ = 10000000;
  // wait lengths of each bring-up phase, in clock cycles
  localparam int DEV_INIT_CYCLES = 16;
  localparam int MST_INIT_CYCLES = 16;
  localparam int CTL_INIT_CYCLES = 16;
  localparam int MODE_W = 4;
  localparam logic [3:0] MODE_PARALLEL = 4'h0;
  localparam logic [3:0] MODE_RAM = 4'h1;
  localparam logic [3:0] MODE_SERIAL_SLAVE = 4'h2;
  localparam logic [3:0] MODE_CAN = 4'h3;
  localparam logic [3:0] MODE_ETH_A = 4'h4;
  localparam logic [3:0] MODE_OTP = 4'h6;
  localparam logic [3:0] MODE_FLASH = 4'h7;
  localparam logic [3:0] MODE_SYNC_MASTER = 4'h9;
  localparam logic [3:0] MODE_TWO_WIRE_MASTER = 4'hA;
  localparam logic [3:0] MODE_ETH_B = 4'hC;
  localparam logic [3:0] MODE_FAST_FLASH = 4'hF;

  typedef enum logic [3:0] {
    SRC_PARALLEL, SRC_RAM, SRC_SERIAL_SLAVE, SRC_CAN, SRC_ETHERNET,
    SRC_SYNC_MASTER, SRC_TWO_WIRE_MASTER, SRC_OTP, SRC_FLASH
  } boot_src_t;

  // decoded boot choice handed to the loader logic
  typedef struct packed {
    boot_src_t src;
    logic alt_pins;
    logic fast_flash;
  } boot_sel_t;
endpackage

// file: verilog/strap_sync.sv
// two-stage synchroniser for the four boot strap pads
// assumes the pads are asynchronous to clk_i
`timescale 1ns/10ps
module strap_sync #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk_i) begin
    meta <= async_i;
    sync_o <= meta;
  end
endmodule

// file: dv/boot_seq_monitor.sv
// port checker for the boot sequencer
// assumes small init lengths (4 cycles each) set by the bench
`timescale 1ns/10ps
module boot_seq_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic master_to_control_wake_irq_i,
  input wire logic control_reset_o,
  input wire logic analog_bus_reset_o,
  input wire logic control_idle_o,
  input wire logic control_running_o,
  input wire logic mode_valid_o,
  input wire logic [3:0] boot_mode_o,
  input wire boot_seq_pkg::boot_sel_t boot_sel_o,
  input wire logic hard_fault_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // subsystems stay held for the first three cycles after reset exit
  hold_after_exit_a: assert property (
    $fell(rst_i) |-> control_reset_o [*3]) else $error("early release");
  release_together_a: assert property (
    control_reset_o == analog_bus_reset_o) else $error("resets differ");
  sample_after_release_a: assert property (
    $rose(mode_valid_o) |-> !control_reset_o) else $error("early sample");
  mode_held_a: assert property (
    $past(mode_valid_o) && mode_valid_o |-> $stable(boot_mode_o))
    else $error("mode changed");
  fast_flash_a: assert property (
    mode_valid_o |-> boot_sel_o.fast_flash == (boot_mode_o == 4'hF))
    else $error("fast flash wrong");
  alt_pins_a: assert property (
    mode_valid_o |-> boot_sel_o.alt_pins == (boot_mode_o == 4'hC))
    else $error("alt pins wrong");
  // idle and running both lag the control state by one register, so the
  // wake that could have moved it is the one sampled a cycle earlier
  idle_waits_a: assert property (
    control_idle_o && !$past(master_to_control_wake_irq_i)
    |=> !control_running_o)
    else $error("woke without irq");
  wake_from_idle_a: assert property (
    $rose(control_running_o) |-> $past(control_idle_o))
    else $error("run not from idle");
  control_boots_a: assert property (
    $fell(control_reset_o) |-> ##[1:40] control_idle_o)
    else $error("control never idles");
  fault_restart_a: assert property (
    hard_fault_o |-> ##[0:2] control_reset_o) else $error("no restart");
endmodule
bind dual_core_boot_sequencer boot_seq_monitor u_boot_seq_monitor (
  .clk_i(clk_i), .rst_i(rst_i),
  .master_to_control_wake_irq_i(master_to_control_wake_irq_i),
  .control_reset_o(control_reset_o), .analog_bus_reset_o(analog_bus_reset_o),
  .control_idle_o(control_idle_o), .control_running_o(control_running_o),
  .mode_valid_o(mode_valid_o), .boot_mode_o(boot_mode_o),
  .boot_sel_o(boot_sel_o), .hard_fault_o(hard_fault_o));

// file: dv/boot_board_model.sv
// board straps and external boot host
// assumes the bench picks the strap level and host speed
`timescale 1ns/10ps
module boot_board_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] level_i,
  input wire logic slow_i,
  input wire logic loader_start_i,
  output logic [3:0] strap_o,
  output logic load_done_o
);
  logic [3:0] delay;
  // pads always driven, never left floating
  assign strap_o = level_i;
  // host answers one or four cycles after the loader starts
  always_ff @(posedge clk_i) begin
    if (rst_i) delay <= 4'h0;
    else delay <= {delay[2:0], loader_start_i};
  end
  assign load_done_o = slow_i ? delay[3] : delay[0];
endmodule

// file: dv/dual_core_boot_sequencer_tb_top.sv
// self-checking bench: every strap mode, wake, strap noise, blank flash
// assumes init lengths cut to 4 cycles, non-engineering version
`timescale 1ns/10ps
module dual_core_boot_sequencer_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, wake = 1'b0, flash_ok = 1'b1;
  logic slow = 1'b0;
  logic [3:0] level = 4'h0, strap, mode;
  logic ld_start, ld_done, c_rst, a_rst, idle, run, mv, app, fault;
  boot_seq_pkg::boot_sel_t sel;
  int failures = 0, total_checks = 0, cycles = 0, n;
  logic [31:0] seed = 32'h3;
  // 10 MHz oscillator, kept under the fast-flash clock ceiling
  initial forever #50 clk_i = ~clk_i;
  dual_core_boot_sequencer #(.DEV_INIT(4), .MST_INIT(4), .CTL_INIT(4))
    u_dual_core_boot_sequencer (.clk_i(clk_i), .rst_i(rst_i),
    .boot_strap_one_i(strap[0]), .boot_strap_two_i(strap[1]),
    .boot_strap_three_i(strap[2]), .boot_strap_four_i(strap[3]),
    .master_to_control_wake_irq_i(wake), .flash_valid_i(flash_ok),
    .load_done_i(ld_done), .control_reset_o(c_rst),
    .analog_bus_reset_o(a_rst), .control_idle_o(idle),
    .control_running_o(run), .mode_valid_o(mv), .boot_mode_o(mode),
    .boot_sel_o(sel), .loader_start_o(ld_start), .app_running_o(app),
    .hard_fault_o(fault));
  boot_board_model u_boot_board_model (.clk_i(clk_i), .rst_i(rst_i),
    .level_i(level), .slow_i(slow), .loader_start_i(ld_start),
    .strap_o(strap), .load_done_o(ld_done));
  function automatic void xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction
  // reference decode of the strap number into a boot source index
  function automatic int exp_src(int m);
    case (m)
      0, 1, 2, 3: return m;
      4, 12: return 4;
      9: return 5;
      10: return 6;
      default: return 8;
    endcase
  endfunction
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait, then the flag must be high
  task automatic wait_hi(string what, ref logic s);
    for (n = 0; n < 100 && s !== 1'b1; n++) @(negedge clk_i);
    check(what, s, 1);
  endtask
  // reset the master with a given strap level and flash state
  task automatic boot(input logic [3:0] m, input logic ok);
    @(posedge clk_i);
    xs();
    rst_i <= 1'b1;
    level <= m;
    flash_ok <= ok;
    slow <= seed[0];
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // subsystems must still be held just after the master leaves reset
    @(negedge clk_i);
    check("ctl_held", c_rst, 1);
    check("bus_held", a_rst, 1);
    wait_hi("mode_valid", mv);
    // the capture follows the release, and the loader is kicked with it
    check("ctl_released", c_rst, 0);
    check("bus_released", a_rst, 0);
    check("loader_start", ld_start, 1);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i); // power-up reset well over eight clocks
    for (int m = 0; m < 16; m++) begin
      boot(m[3:0], 1'b1);
      check("boot_mode", mode, m);
      check("src", sel.src, exp_src(m));
      check("alt_pins", sel.alt_pins, m == 12);
      check("fast", sel.fast_flash, m == 15);
      // strap noise after capture must not reach the mode
      @(posedge clk_i);
      xs();
      level <= seed[7:4];
      repeat (4) @(negedge clk_i);
      check("held_mode", mode, m);
      wait_hi("idle", idle);
      check("running_early", run, 0);
      @(posedge clk_i);
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      wait_hi("running", run);
      wait_hi("app", app);
    end
    boot(4'h7, 1'b0);
    wait_hi("hard_fault", fault);
    wait_hi("restart", c_rst);
    check("no_app", app, 0);
    complete_run();
  end
endmodule
